/* File: rtl/crr_pkg.sv */
// Constants for the codec-link register read logic
package crr_pkg;
	// ------------------------------------------------------------
	// Register addresses (7-bit link register address)
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_PDOWN = 7'h26;
	localparam logic [6:0] ADDR_EXT_AUDIO = 7'h28;
	localparam logic [6:0] ADDR_RATE_FRONT = 7'h2c;
	localparam logic [6:0] ADDR_RATE_SURR = 7'h2e;
	localparam logic [6:0] ADDR_RATE_LFE = 7'h30;
	localparam logic [6:0] ADDR_EXT_MODEM = 7'h3c;
	localparam logic [6:0] ADDR_CFG = 7'h5a;
	localparam logic [6:0] ADDR_AUDIO_TOP = 7'h3a;
	// ------------------------------------------------------------
	// Field positions and values
	// ------------------------------------------------------------
	localparam int PDOWN_BIT = 12;
	localparam int CID_LO_BIT = 14;
	localparam int CID_HI_BIT = 15;
	localparam int FC_BIT = 0;
	localparam logic FC_RESET = 1'b1;
	localparam logic [15:0] RATE_48K = 16'hbb80;
	localparam logic [15:0] RATE_44K1 = 16'hac44;
	// ------------------------------------------------------------
	// Frame layout: slot 0 (16) + slot 1 (20) + slot 2 (20)
	// ------------------------------------------------------------
	localparam int FRAME_W = 56;
	localparam logic [5:0] LAST_BIT = 6'h37;
	localparam int TAG_FRAME = 55;
	localparam int TAG_S1 = 54;
	localparam int TAG_S2 = 53;
	localparam int RD_FLAG = 39;
	localparam int ADDR_HI = 38;
	localparam int ADDR_LO = 32;
	localparam int DATA_HI = 19;
	localparam int DATA_LO = 4;
	// ------------------------------------------------------------
	// Timing: warm reset is a sync pulse with the bit clock idle
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int WARM_NS = 1000;
	localparam int WARM_CYC = (WARM_NS * CLK_MHZ + 999) / 1000;
endpackage

/* File: rtl/crr_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module crr_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	// Elaboration check: a zero-width bus has nothing to sample
	if (W < 1)
	begin : g_bad_w
		$error("crr_pin_sync: W must be at least 1");
	end
	// ------------------------------------------------------------
	// Per-bit chain; stage one feeds only stage two
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic lvl_ff;
			// A change counts only once stages two and three agree
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					lvl_ff <= 1'b0;
				end
				else if (ce)
				begin
					s1_ff <= pin[g];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					if (s2_ff == s3_ff)
						lvl_ff <= s3_ff;
				end
			end
			assign level[g] = lvl_ff;
		end
	endgenerate
endmodule // crr_pin_sync

/* File: rtl/crr_reg_ram.sv */
// Flip-flop register RAM with one write and two read ports
`timescale 1ns/1ps
module crr_reg_ram #(
	parameter int AW = 6,
	parameter int DW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_idx,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_idx_a,
	output logic [DW-1:0] rd_data_a,
	input wire logic [AW-1:0] rd_idx_b,
	output logic [DW-1:0] rd_data_b
);
	logic [DW-1:0] mem_ff [2**AW];
	// Elaboration check: an empty array cannot hold a register
	if (AW < 1 || DW < 1)
	begin : g_bad_size
		$error("crr_reg_ram: AW and DW must be positive");
	end
	// ------------------------------------------------------------
	// One entry per word; whole word stored, reserved bits too
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2**AW; g++)
		begin : g_word
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					mem_ff[g] <= '0;
				else if (ce && wr_en && wr_idx == AW'(g))
					mem_ff[g] <= wr_data;
			end
		end
	endgenerate
	// Asynchronous reads; callers register the result
	assign rd_data_a = mem_ff[rd_idx_a];
	assign rd_data_b = mem_ff[rd_idx_b];
endmodule // crr_reg_ram

/* File: rtl/crr_top.sv */
// Codec-link register bank: link frame handling and read responses
`timescale 1ns/1ps
module crr_top #(
	// Sixteen bits per word index; a 0 marks a reserved bit
	parameter logic [64*16-1:0] RSVD_MASK = {64{16'hffff}}
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic BIT_CLK_I,
	input wire logic SYNC_I,
	input wire logic SDATA_OUT_I,
	input wire logic ADDRESS_SELECT_PIN,
	output logic BIT_CLK_O,
	output logic BIT_CLK_OE,
	output logic SDATA_IN_O,
	input wire logic [5:0] DSP_RD_IDX,
	output logic [15:0] DSP_RD_DATA,
	output logic LINK_POWERDOWN_BIT,
	output logic FULL_COMPLIANCE_SELECT
);
	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	logic [3:0] pins_s;
	logic bclk_s;
	logic sync_s;
	logic sdo_s;
	logic sa_s;
	logic bclk_prev_ff;
	logic sync_prev_ff;
	logic bclk_rise;
	logic bclk_fall;

	crr_pin_sync #(.W(4)) u_sync (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.pin({ADDRESS_SELECT_PIN, SDATA_OUT_I, SYNC_I, BIT_CLK_I}),
		.level(pins_s)
	);
	assign bclk_s = pins_s[0];
	assign sync_s = pins_s[1];
	assign sdo_s = pins_s[2];
	assign sa_s = pins_s[3];

	// Previous levels, for edge detection on the filtered copies
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			bclk_prev_ff <= 1'b0;
			sync_prev_ff <= 1'b0;
		end
		else if (CE)
		begin
			bclk_prev_ff <= bclk_s;
			sync_prev_ff <= sync_s;
		end
	end
	assign bclk_rise = CE && bclk_s && !bclk_prev_ff;
	assign bclk_fall = CE && !bclk_s && bclk_prev_ff;

	// ------------------------------------------------------------
	// Frame receive: slot 0, slot 1 and slot 2 shifted in
	// ------------------------------------------------------------
	logic sync_pend_ff;
	logic rx_act_ff;
	logic [5:0] bit_cnt_ff;
	logic [crr_pkg::FRAME_W-1:0] rx_ff;
	logic [crr_pkg::FRAME_W-1:0] nxt_rx;
	logic frame_start;
	logic cmd_done;

	assign frame_start = bclk_rise && sync_pend_ff;
	assign nxt_rx = {rx_ff[crr_pkg::FRAME_W-2:0], sdo_s};
	assign cmd_done = bclk_fall && rx_act_ff
		&& bit_cnt_ff == crr_pkg::LAST_BIT;

	// A sync rise arms a frame that begins at the next bit clock rise
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			sync_pend_ff <= 1'b0;
		else if (CE)
		begin
			if (sync_s && !sync_prev_ff)
				sync_pend_ff <= 1'b1;
			else if (frame_start)
				sync_pend_ff <= 1'b0;
		end
	end

	// Serial data from the controller is taken on falling bit clock
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			rx_act_ff <= 1'b0;
			bit_cnt_ff <= '0;
			rx_ff <= '0;
		end
		else if (frame_start)
		begin
			rx_act_ff <= 1'b1;
			bit_cnt_ff <= '0;
		end
		else if (bclk_fall && rx_act_ff)
		begin
			rx_ff <= nxt_rx;
			bit_cnt_ff <= bit_cnt_ff + 6'h01;
			if (bit_cnt_ff == crr_pkg::LAST_BIT)
				rx_act_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Command decode from the completed slots
	// ------------------------------------------------------------
	logic cmd_ok;
	logic cmd_rd;
	logic cmd_wr;
	logic [6:0] cmd_addr;
	logic [15:0] cmd_data;
	logic cmd_odd;
	logic is_rate;
	logic is_cid;

	assign cmd_ok = nxt_rx[crr_pkg::TAG_FRAME] && nxt_rx[crr_pkg::TAG_S1];
	assign cmd_addr = nxt_rx[crr_pkg::ADDR_HI:crr_pkg::ADDR_LO];
	assign cmd_data = nxt_rx[crr_pkg::DATA_HI:crr_pkg::DATA_LO];
	assign cmd_odd = cmd_addr[0];
	assign cmd_rd = cmd_done && cmd_ok && nxt_rx[crr_pkg::RD_FLAG];
	// Odd addresses never reach RAM or control flops
	assign cmd_wr = cmd_done && cmd_ok && !nxt_rx[crr_pkg::RD_FLAG]
		&& nxt_rx[crr_pkg::TAG_S2] && !cmd_odd;
	assign is_rate = cmd_addr == crr_pkg::ADDR_RATE_FRONT
		|| cmd_addr == crr_pkg::ADDR_RATE_SURR
		|| cmd_addr == crr_pkg::ADDR_RATE_LFE;
	assign is_cid = cmd_addr == crr_pkg::ADDR_EXT_AUDIO
		|| cmd_addr == crr_pkg::ADDR_EXT_MODEM;

	// ------------------------------------------------------------
	// Register RAM: link writes, link and DSP reads
	// ------------------------------------------------------------
	logic [15:0] ram_link;
	logic [15:0] ram_dsp;

	crr_reg_ram #(.AW(6), .DW(16)) u_ram (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.wr_en(cmd_wr),
		.wr_idx(cmd_addr[6:1]),
		.wr_data(cmd_data),
		.rd_idx_a(cmd_addr[6:1]),
		.rd_data_a(ram_link),
		.rd_idx_b(DSP_RD_IDX),
		.rd_data_b(ram_dsp)
	);

	// DSP sees plain RAM; the pin level has no path here
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			DSP_RD_DATA <= '0;
		else if (CE)
			DSP_RD_DATA <= ram_dsp;
	end

	// ------------------------------------------------------------
	// Control flip-flops: powerdown, rate flag, compliance select
	// ------------------------------------------------------------
	logic pdown_ff;
	logic rate_ff;
	logic fc_ff;
	logic [7:0] warm_cnt_ff;
	logic warm_hit;

	// Sync held high with no bit clock edge for the warm-reset time
	assign warm_hit = CE && warm_cnt_ff == 8'(crr_pkg::WARM_CYC - 1)
		&& sync_s && !bclk_rise && !bclk_fall;
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			warm_cnt_ff <= '0;
		else if (CE)
		begin
			if (!sync_s || bclk_rise || bclk_fall)
				warm_cnt_ff <= '0;
			else if (warm_cnt_ff != 8'(crr_pkg::WARM_CYC))
				warm_cnt_ff <= warm_cnt_ff + 8'h01;
		end
	end

	// Warm reset wins over a write in the same cycle
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			pdown_ff <= 1'b0;
		else if (warm_hit)
			pdown_ff <= 1'b0;
		else if (cmd_wr && cmd_addr == crr_pkg::ADDR_PDOWN)
			pdown_ff <= cmd_data[crr_pkg::PDOWN_BIT];
	end

	// Rate flag follows the last write to any of the three rate words
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			rate_ff <= 1'b0;
		else if (cmd_wr && is_rate)
			rate_ff <= cmd_data == crr_pkg::RATE_44K1;
	end

	// Compliance select starts set and tracks bit 0 of the config word
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			fc_ff <= crr_pkg::FC_RESET;
		else if (cmd_wr && cmd_addr == crr_pkg::ADDR_CFG)
			fc_ff <= cmd_data[crr_pkg::FC_BIT];
	end

	// ------------------------------------------------------------
	// Read word composition
	// ------------------------------------------------------------
	logic [15:0] rd_word;
	always_comb
	begin
		rd_word = ram_link;
		// Masking first, so live fields below are never cleared
		if (fc_ff && cmd_addr <= crr_pkg::ADDR_AUDIO_TOP)
			rd_word = rd_word & RSVD_MASK[cmd_addr[6:1]*16 +: 16];
		// Only the two index bits move; the rest stays as RAM and the mask above leave it
		if (is_cid)
		begin
			rd_word[crr_pkg::CID_LO_BIT] = sa_s;
			rd_word[crr_pkg::CID_HI_BIT] = 1'b0;
		end
		if (cmd_addr == crr_pkg::ADDR_PDOWN)
			rd_word[crr_pkg::PDOWN_BIT] = pdown_ff;
		if (cmd_addr == crr_pkg::ADDR_CFG)
			rd_word[crr_pkg::FC_BIT] = fc_ff;
		if (is_rate)
			rd_word = rate_ff ? crr_pkg::RATE_44K1 : crr_pkg::RATE_48K;
		if (cmd_odd)
			rd_word = '0;
	end

	// ------------------------------------------------------------
	// Response held until the next frame, then shifted out
	// ------------------------------------------------------------
	logic rsp_val_ff;
	logic [6:0] rsp_addr_ff;
	logic [15:0] rsp_data_ff;
	logic [crr_pkg::FRAME_W-1:0] tx_ff;
	logic [crr_pkg::FRAME_W-1:0] tx_frame;

	// Answer latched at the end of a read command, valid until the next frame starts
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			rsp_val_ff <= 1'b0;
			rsp_addr_ff <= '0;
			rsp_data_ff <= '0;
		end
		else if (cmd_rd)
		begin
			rsp_val_ff <= 1'b1;
			rsp_addr_ff <= cmd_addr;
			rsp_data_ff <= rd_word;
		end
		else if (frame_start)
			rsp_val_ff <= 1'b0;
	end

	// Slot 0: ready, slot1 and slot2 tags; slot 1 echo; slot 2 data
	assign tx_frame = {1'b1, rsp_val_ff, rsp_val_ff, 13'h0000,
		1'b0, rsp_addr_ff, 12'h000, rsp_data_ff, 4'h0};

	// Driven on rising bit clock; forced low while powered down
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			tx_ff <= '0;
			SDATA_IN_O <= 1'b0;
		end
		else if (CE && pdown_ff)
		begin
			tx_ff <= '0;
			SDATA_IN_O <= 1'b0;
		end
		else if (frame_start)
		begin
			tx_ff <= {tx_frame[crr_pkg::FRAME_W-2:0], 1'b0};
			SDATA_IN_O <= tx_frame[crr_pkg::FRAME_W-1];
		end
		else if (bclk_rise)
		begin
			tx_ff <= {tx_ff[crr_pkg::FRAME_W-2:0], 1'b0};
			SDATA_IN_O <= tx_ff[crr_pkg::FRAME_W-1];
		end
	end

	// Bit clock pad pulled low by enabling a low driver
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			BIT_CLK_O <= 1'b0;
			BIT_CLK_OE <= 1'b0;
			LINK_POWERDOWN_BIT <= 1'b0;
			FULL_COMPLIANCE_SELECT <= crr_pkg::FC_RESET;
		end
		else if (CE)
		begin
			BIT_CLK_O <= 1'b0;
			BIT_CLK_OE <= pdown_ff;
			LINK_POWERDOWN_BIT <= pdown_ff;
			FULL_COMPLIANCE_SELECT <= fc_ff;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_odd_zero;
		@(posedge CLK) disable iff (!RST_N)
		cmd_rd && cmd_odd |=> rsp_val_ff && rsp_data_ff == 16'h0000;
	endproperty
	a_odd_zero: assert property (p_odd_zero)
		else $error("odd read data not zero");

	property p_odd_echo;
		@(posedge CLK) disable iff (!RST_N)
		cmd_rd && cmd_odd |=> rsp_addr_ff == $past(cmd_addr);
	endproperty
	a_odd_echo: assert property (p_odd_echo)
		else $error("odd address not echoed");

	property p_odd_keep;
		@(posedge CLK) disable iff (!RST_N)
		cmd_done && cmd_odd |-> !cmd_wr ##1 $stable(pdown_ff)
			&& $stable(rate_ff) && $stable(fc_ff);
	endproperty
	a_odd_keep: assert property (p_odd_keep)
		else $error("odd access changed control state");

	property p_pdown_low;
		@(posedge CLK) disable iff (!RST_N)
		pdown_ff && CE |=> !SDATA_IN_O && BIT_CLK_OE && !BIT_CLK_O;
	endproperty
	a_pdown_low: assert property (p_pdown_low)
		else $error("powerdown did not force link low");

	property p_warm;
		@(posedge CLK) disable iff (!RST_N)
		warm_hit |=> !pdown_ff ##[1:2] !LINK_POWERDOWN_BIT;
	endproperty
	a_warm: assert property (p_warm)
		else $error("warm reset left powerdown set");

	property p_rate;
		@(posedge CLK) disable iff (!RST_N)
		cmd_rd && is_rate |=> rsp_data_ff == (rate_ff ?
			crr_pkg::RATE_44K1 : crr_pkg::RATE_48K);
	endproperty
	a_rate: assert property (p_rate)
		else $error("rate read value wrong");

	property p_rate_upd;
		@(posedge CLK) disable iff (!RST_N)
		cmd_wr && is_rate |=> rate_ff == ($past(cmd_data)
			== crr_pkg::RATE_44K1);
	endproperty
	a_rate_upd: assert property (p_rate_upd)
		else $error("rate flag not updated");

	property p_cid;
		@(posedge CLK) disable iff (!RST_N)
		cmd_rd && is_cid |=> !rsp_data_ff[crr_pkg::CID_HI_BIT]
			&& rsp_data_ff[crr_pkg::CID_LO_BIT] == $past(sa_s);
	endproperty
	a_cid: assert property (p_cid)
		else $error("codec index bits wrong");

	property p_fc_reset;
		@(posedge CLK) $past(!RST_N) |-> fc_ff;
	endproperty
	a_fc_reset: assert property (p_fc_reset)
		else $error("compliance not selected after reset");

	property p_pdown_read;
		@(posedge CLK) disable iff (!RST_N)
		cmd_rd && cmd_addr == crr_pkg::ADDR_PDOWN |=>
			rsp_data_ff[crr_pkg::PDOWN_BIT] == pdown_ff;
	endproperty
	a_pdown_read: assert property (p_pdown_read)
		else $error("powerdown read not live");

	c_odd_read: cover property (@(posedge CLK) disable iff (!RST_N)
		cmd_rd && cmd_odd);
	c_rate_read: cover property (@(posedge CLK) disable iff (!RST_N)
		cmd_rd && is_rate && rate_ff);
	c_warm: cover property (@(posedge CLK) disable iff (!RST_N)
		pdown_ff ##1 warm_hit);
endmodule // crr_top

/* File: sim/crr_link_ctrl.sv */
// Link controller model that frames bit clock, sync and command data
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far-side link controller
// ------------------------------------------------------------
module crr_link_ctrl (
	output logic bit_clk,
	output logic sync,
	output logic sdata_out,
	input wire logic sdata_in
);
	// Bit clock stands low between frames
	initial
	begin
		bit_clk = 1'b0;
		sync = 1'b0;
		sdata_out = 1'b1;
	end

	// One 56-bit frame; reply sampled late in each bit, past sync lag
	task automatic run_frame(
		input logic [55:0] tx,
		output logic [55:0] rx
	);
		int i;
		sync = 1'b1;
		#37;
		for (i = 0; i < 56; i++)
		begin
			if (i == 16)
				sync = 1'b0;
			bit_clk = 1'b1;
			sdata_out = tx[55 - i];
			#32;
			bit_clk = 1'b0;
			#28;
			rx[55 - i] = sdata_in;
			#4;
		end
		// Released data line shows the inverse, never a stale value
		sdata_out = ~sdata_out;
		#200;
	endtask

	// Warm reset: sync high while the bit clock stays still
	task automatic warm_reset();
		sync = 1'b1;
		#1200;
		sync = 1'b0;
		#200;
	endtask
endmodule // crr_link_ctrl

/* File: sim/tb_top.sv */
// Self-checking testbench for the codec-link register read logic
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("BAD %0t got %h exp %h", $time, (g), (e)); \
		end \
	end
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb_top;
	// Word 1 hides its top nibble; word 32 mask must never apply
	localparam logic [1023:0] MASK = {64{16'hffff}} &
		~(1024'hf000 << 16) & ~(1024'hff00 << 512);
	logic clk;
	logic rst_n;
	logic addr_sel;
	logic [5:0] dsp_idx;
	logic bclk_o;
	logic bclk_oe;
	logic sdin;
	logic pd;
	logic fc;
	logic [15:0] dsp_data;
	logic m_bclk;
	logic m_sync;
	logic m_sdo;
	logic bclk_wire;
	int err_count;
	int cmp_count;
	logic [55:0] r;
	logic [15:0] d;

	// Device drives the shared bit clock low only while enabled
	assign bclk_wire = bclk_oe ? bclk_o : m_bclk;

	crr_top #(.RSVD_MASK(MASK)) u_crr_top (
		.CLK(clk),
		.RST_N(rst_n),
		.CE(1'b1),
		.BIT_CLK_I(bclk_wire),
		.SYNC_I(m_sync),
		.SDATA_OUT_I(m_sdo),
		.ADDRESS_SELECT_PIN(addr_sel),
		.BIT_CLK_O(bclk_o),
		.BIT_CLK_OE(bclk_oe),
		.SDATA_IN_O(sdin),
		.DSP_RD_IDX(dsp_idx),
		.DSP_RD_DATA(dsp_data),
		.LINK_POWERDOWN_BIT(pd),
		.FULL_COMPLIANCE_SELECT(fc)
	);

	crr_link_ctrl u_crr_link_ctrl (
		.bit_clk(m_bclk),
		.sync(m_sync),
		.sdata_out(m_sdo),
		.sdata_in(sdin)
	);

	always #4 clk = ~clk;

	// Verdict and end of run
	task test_done();
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Link write of one word, tagged in slots 1 and 2
	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		logic [55:0] f;
		logic [55:0] x;
		f = '0;
		f[crr_pkg::TAG_FRAME] = 1'b1;
		f[crr_pkg::TAG_S1] = 1'b1;
		f[crr_pkg::TAG_S2] = 1'b1;
		f[crr_pkg::ADDR_HI:crr_pkg::ADDR_LO] = a;
		f[crr_pkg::DATA_HI:crr_pkg::DATA_LO] = v;
		u_crr_link_ctrl.run_frame(f, x);
	endtask

	// Link read; the answer arrives in the following idle frame
	task automatic rd(input logic [6:0] a, output logic [55:0] y);
		logic [55:0] f;
		f = '0;
		f[crr_pkg::TAG_FRAME] = 1'b1;
		f[crr_pkg::TAG_S1] = 1'b1;
		f[crr_pkg::RD_FLAG] = 1'b1;
		f[crr_pkg::ADDR_HI:crr_pkg::ADDR_LO] = a;
		u_crr_link_ctrl.run_frame(f, y);
		u_crr_link_ctrl.run_frame(56'h0, y);
		d = y[crr_pkg::DATA_HI:crr_pkg::DATA_LO];
	endtask

	// DSP port read; answer one edge later, sampled after it lands
	task automatic dsp(input logic [5:0] i);
		@(posedge clk);
		dsp_idx <= i;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic t_reset();
		`CHK(fc, 1'b1)
		`CHK(pd, 1'b0)
		`CHK(bclk_oe, 1'b0)
		rd(7'h5a, r);
		`CHK(d[0], 1'b1)
	endtask

	// Masked low register, unmasked register above audio space
	task automatic t_plain();
		wr(7'h02, 16'habcd);
		rd(7'h02, r);
		`CHK(d, 16'h0bcd)
		dsp(6'h01);
		`CHK(dsp_data, 16'habcd)
		wr(7'h40, 16'h1234);
		rd(7'h40, r);
		`CHK(d, 16'h1234)
	endtask

	// Low codec index bit follows the pin, high index bit reads 0, rest from RAM
	task automatic t_codec();
		wr(7'h3c, 16'hffff);
		@(posedge clk);
		addr_sel <= 1'b1;
		rd(7'h3c, r);
		`CHK(d, 16'h7fff)
		rd(7'h28, r);
		`CHK(d[15:14], 2'b01)
		dsp(6'h1e);
		`CHK(dsp_data, 16'hffff)
		@(posedge clk);
		addr_sel <= 1'b0;
		rd(7'h3c, r);
		`CHK(d, 16'h3fff)
	endtask

	// Rate registers read back one of two codes, set by the last write to any of them
	task automatic t_rate();
		logic [6:0] ra [3] = '{7'h2c, 7'h2e, 7'h30};
		wr(7'h2c, 16'hac44);
		foreach (ra[k])
		begin
			rd(ra[k], r);
			`CHK(d, crr_pkg::RATE_44K1)
		end
		wr(7'h2e, 16'h1234);
		foreach (ra[k])
		begin
			rd(ra[k], r);
			`CHK(d, crr_pkg::RATE_48K)
		end
		wr(7'h30, 16'hac44);
		rd(7'h2e, r);
		`CHK(d, crr_pkg::RATE_44K1)
	endtask

	task automatic t_odd();
		rd(7'h03, r);
		`CHK(r[crr_pkg::TAG_S1], 1'b1)
		`CHK(r[crr_pkg::TAG_S2], 1'b1)
		`CHK(d, 16'h0000)
		`CHK(r[crr_pkg::ADDR_HI:crr_pkg::ADDR_LO], 7'h03)
		wr(7'h03, 16'h5555);
		rd(7'h02, r);
		`CHK(d, 16'h0bcd)
		`CHK(fc, 1'b1)
	endtask

	task automatic t_fc();
		wr(7'h5a, 16'h0000);
		`CHK(fc, 1'b0)
		rd(7'h02, r);
		`CHK(d, 16'habcd)
		wr(7'h5a, 16'h0001);
		`CHK(fc, 1'b1)
	endtask

	// Powerdown, warm reset, then live bit against the stale RAM copy
	task automatic t_pdown();
		wr(7'h26, 16'h1000);
		`CHK(pd, 1'b1)
		`CHK(bclk_oe, 1'b1)
		`CHK(bclk_o, 1'b0)
		`CHK(sdin, 1'b0)
		u_crr_link_ctrl.warm_reset();
		`CHK(pd, 1'b0)
		`CHK(bclk_oe, 1'b0)
		rd(7'h26, r);
		`CHK(d[12], 1'b0)
		dsp(6'h13);
		`CHK(dsp_data[12], 1'b1)
	endtask

	// Sequence: reset for 10 cycles, then one task per scenario
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		addr_sel = 1'b0;
		dsp_idx = 6'h00;
		err_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		t_reset();
		t_plain();
		t_codec();
		t_rate();
		t_odd();
		t_fc();
		t_pdown();
		test_done();
	end

	// Watchdog: about 2.4 times the expected run length
	initial
	begin
		#400000;
		err_count++;
		test_done();
	end
endmodule // tb_top
